//--- verilog/rtc_pkg.sv
package rtc_pkg;
	localparam int          CLK_FREQ_HZ    = 50_000_000;
	localparam int          DETECT_TIME_US = 500;
	localparam int          DETECT_CYCLES  =
		DETECT_TIME_US * (CLK_FREQ_HZ / 1_000_000);
	localparam logic [2:0]  DETECT_EDGES   = 3'h4;
	localparam logic [5:0]  FIX_DIV_LAST   = 6'h3F;
	localparam logic [19:0] PRESCALE_RST   = 20'h0_0000;

	localparam logic [7:0]  ADDR_CLK_CTRL  = 8'h00;
	localparam logic [7:0]  ADDR_PRESCALE  = 8'h04;
	localparam logic [7:0]  ADDR_TIME      = 8'h08;
	localparam logic [7:0]  ADDR_ALARM     = 8'h0C;
	localparam logic [7:0]  ADDR_CYCLE_N   = 8'h10;
	localparam logic [7:0]  ADDR_DIVIDER   = 8'h14;
	localparam logic [7:0]  ADDR_STATUS    = 8'h18;
	localparam logic [7:0]  ADDR_MASK      = 8'h1C;
	localparam logic [7:0]  ADDR_WAKE_DLY  = 8'h20;
	localparam logic [7:0]  ADDR_SRC_SEL   = 8'h24;
	localparam logic [7:0]  ADDR_SYS_CFG   = 8'h28;
	localparam logic [7:0]  ADDR_CLK_INFO  = 8'h2C;

	localparam int          CTRL_RUN       = 0;
	localparam int          CTRL_OSC_OFF   = 1;
	localparam int          CTRL_CYC_EN    = 2;
	localparam int          SEL_TICK       = 0;
	localparam int          SEL_ALARM      = 1;
	localparam int          CFG_PWD_WAKE   = 0;
	localparam int          INFO_LP_SEL    = 0;
	localparam int          INFO_DET_DONE  = 1;
	localparam int          INFO_MAIN_ON   = 2;
	localparam int          INFO_LP_ON     = 3;

	localparam int          ST_TICK        = 0;
	localparam int          ST_ALARM       = 1;
	localparam int          ST_CYCLE       = 2;
	localparam int          ST_WAKE        = 3;

	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage : rtc_pkg

//--- verilog/rtc_prescaler_alarm_counter.sv
// Functional notes
// R1 - Counter runs from main or 32 kHz source, optionally through power down.
// R2 - Reference divider input is the clock divided by a fixed 64.
// R3 - 20-bit divider reloads from prescale value at every basic tick.
// R4 - A tick interrupt request may be issued once per basic tick.
// R5 - 32-bit software-loadable time counter advances on each basic tick.
// R6 - Alarm request raised when time counter equals the 32-bit alarm.
// R7 - Optional cyclic request after a programmable number n of ticks.
// R8 - Fixed stage, divider and time counter form one 58-bit timer.
// R9 - Tick and alarm requests routable to a fast wake-capable interrupt.
// R10 - With wake configured, power down is left after a programmed delay.
// R11 - Oscillator-off bit stops the clock oscillator on power down entry.
// R12 - Disabled clock plus power down switches off both oscillators.
// R13 - After reset, detect 32 kHz activity and select it if present.
// R14 - With 32 kHz source, power down turns the main oscillator off.
// R15 - With 32 kHz source, counter and oscillator keep running in stand-by.
// R16 - Without 32 kHz, main oscillator clocks counter; stops in stand-by.
// R17 - Main source, clock enabled: main oscillator kept on in power down.
// R18 - Registers are reached only over the peripheral bus.
// R19 - Alarm request is one event on the tick equality first occurs.
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module rtc_prescaler_alarm_counter #(
	parameter int DETECT_CYCLES = rtc_pkg::DETECT_CYCLES
) (
	input  wire logic        clk,                        // System clock
	input  wire logic        nrst,                       // Sync reset, low
	input  wire logic        low_power_oscillator_input, // 32 kHz pin
	input  wire logic        powerdown_mode,             // Chip in power down
	input  wire logic        standby_mode,               // Main supply removed
	input  wire logic [7:0]  s_axi_awaddr,               // Write address
	input  wire logic        s_axi_awvalid,              // Write addr valid
	output logic             s_axi_awready,              // Write addr ready
	input  wire logic [31:0] s_axi_wdata,                // Write data
	input  wire logic [3:0]  s_axi_wstrb,                // Byte enables
	input  wire logic        s_axi_wvalid,               // Write data valid
	output logic             s_axi_wready,               // Write data ready
	output logic [1:0]       s_axi_bresp,                // Write response
	output logic             s_axi_bvalid,               // Response valid
	input  wire logic        s_axi_bready,               // Response ready
	input  wire logic [7:0]  s_axi_araddr,               // Read address
	input  wire logic        s_axi_arvalid,              // Read addr valid
	output logic             s_axi_arready,              // Read addr ready
	output logic [31:0]      s_axi_rdata,                // Read data
	output logic [1:0]       s_axi_rresp,                // Read response
	output logic             s_axi_rvalid,               // Read data valid
	input  wire logic        s_axi_rready,               // Read data ready
	output logic             irq,                        // Masked status
	output logic             tick_interrupt_request,     // Tick pulse
	output logic             alarm_interrupt_request,    // Alarm pulse
	output logic             fast_ext_irq,               // Routed request
	output logic             wake_request,               // Leave power down
	output logic             main_osc_enable,            // Main osc on
	output logic             lp_osc_enable               // 32 kHz osc on
);

	if (DETECT_CYCLES < 2 || DETECT_CYCLES > 65535) begin : g_bad_det
		$error("DETECT_CYCLES out of range");
	end

	localparam logic [15:0] DET_LAST = 16'(DETECT_CYCLES - 1);

	typedef struct packed {
		logic        lp_s1;
		logic        lp_s2;
		logic        lp_s3;
		logic [15:0] det_cnt;
		logic [2:0]  edge_cnt;
		logic        det_done;
		logic        lp_sel;
		logic [5:0]  fix_cnt;
		logic [19:0] div_cnt;
		logic [31:0] time_cnt;
		logic        run;
		logic        osc_off;
		logic        cyc_en;
		logic [19:0] prescale;
		logic [31:0] alarm;
		logic [31:0] cyc_n;
		logic [31:0] cyc_cnt;
		logic [3:0]  status;
		logic [3:0]  mask;
		logic [31:0] wake_dly;
		logic [31:0] wake_cnt;
		logic        wake_arm;
		logic        sel_tick;
		logic        sel_alarm;
		logic        pwd_wake;
		logic        pd_d;
		logic        tick_req;
		logic        alarm_req;
		logic        ext_irq;
		logic        wake;
		logic        aw_got;
		logic        w_got;
		logic [7:0]  aw_addr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
	} state_t;

	state_t      s_r;
	state_t      s_nxt;
	logic        lp_rise;
	logic        base_en;
	logic        pre_pulse;
	logic        tick;
	logic        time_wr;
	logic        alarm_hit;
	logic        cyc_hit;
	logic        wake_hit;
	logic        wr_do;
	logic        rd_do;
	logic [3:0]  events;
	logic [3:0]  st_clr;
	logic [31:0] time_inc;
	logic [31:0] wv;

	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] d, input logic [3:0] b);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (b[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic [31:0] rd_mux(input state_t s,
		input logic [7:0] a, input logic mon, input logic lon);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (a)
			rtc_pkg::ADDR_CLK_CTRL: begin
				r[rtc_pkg::CTRL_RUN]     = s.run;
				r[rtc_pkg::CTRL_OSC_OFF] = s.osc_off;
				r[rtc_pkg::CTRL_CYC_EN]  = s.cyc_en;
			end
			rtc_pkg::ADDR_PRESCALE: r[19:0] = s.prescale;
			rtc_pkg::ADDR_TIME:     r = s.time_cnt;
			rtc_pkg::ADDR_ALARM:    r = s.alarm;
			rtc_pkg::ADDR_CYCLE_N:  r = s.cyc_n;
			rtc_pkg::ADDR_DIVIDER:  r[25:0] = {s.fix_cnt, s.div_cnt}; // R8
			rtc_pkg::ADDR_STATUS:   r[3:0] = s.status;
			rtc_pkg::ADDR_MASK:     r[3:0] = s.mask;
			rtc_pkg::ADDR_WAKE_DLY: r = s.wake_dly;
			rtc_pkg::ADDR_SRC_SEL: begin
				r[rtc_pkg::SEL_TICK]  = s.sel_tick;
				r[rtc_pkg::SEL_ALARM] = s.sel_alarm;
			end
			rtc_pkg::ADDR_SYS_CFG:  r[rtc_pkg::CFG_PWD_WAKE] = s.pwd_wake;
			rtc_pkg::ADDR_CLK_INFO: begin
				r[rtc_pkg::INFO_LP_SEL]   = s.lp_sel;
				r[rtc_pkg::INFO_DET_DONE] = s.det_done;
				r[rtc_pkg::INFO_MAIN_ON]  = mon;
				r[rtc_pkg::INFO_LP_ON]    = lon;
			end
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction : rd_mux

	function automatic logic mapped(input logic [7:0] a);
		return a[1:0] == 2'h0 && a <= rtc_pkg::ADDR_CLK_INFO;
	endfunction : mapped

	// Oscillator gating; the selected source decides what may stop
	assign main_osc_enable = !standby_mode &&  // R15 R16
		!(powerdown_mode && (s_r.lp_sel || !s_r.run || // R14 R12 R17
		s_r.osc_off));                             // R11
	assign lp_osc_enable = !((powerdown_mode || standby_mode) &&
		(!s_r.run || s_r.osc_off || !s_r.lp_sel)); // R11 R12 R15

	assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
	assign s_axi_wready  = !s_r.w_got && !s_r.bvalid;
	assign s_axi_arready = !s_r.rvalid;
	assign s_axi_bvalid  = s_r.bvalid;
	assign s_axi_bresp   = s_r.bresp;
	assign s_axi_rvalid  = s_r.rvalid;
	assign s_axi_rresp   = s_r.rresp;
	assign s_axi_rdata   = s_r.rdata;
	assign irq                     = |(s_r.status & s_r.mask);
	assign tick_interrupt_request  = s_r.tick_req;
	assign alarm_interrupt_request = s_r.alarm_req;
	assign fast_ext_irq            = s_r.ext_irq;
	assign wake_request            = s_r.wake;

	always_comb begin
		s_nxt = s_r;
		s_nxt.lp_s1 = low_power_oscillator_input;
		s_nxt.lp_s2 = s_r.lp_s1;
		s_nxt.lp_s3 = s_r.lp_s2;
		lp_rise = s_r.lp_s2 && !s_r.lp_s3;

		// Source detection window once after every reset
		if (!s_r.det_done) begin // R13
			s_nxt.det_cnt = s_r.det_cnt + 16'h0001;
			if (lp_rise && s_r.edge_cnt != rtc_pkg::DETECT_EDGES) begin
				s_nxt.edge_cnt = s_r.edge_cnt + 3'h1;
			end
			if (s_r.det_cnt == DET_LAST) begin
				s_nxt.det_done = 1'b1;
				s_nxt.lp_sel = s_r.edge_cnt == rtc_pkg::DETECT_EDGES;
			end
		end

		// Base pulse: 32 kHz edge or one system clock, only while running
		base_en = s_r.run && (s_r.lp_sel ? (lp_rise && lp_osc_enable) // R1
			: main_osc_enable); // R16
		pre_pulse = base_en && s_r.fix_cnt == rtc_pkg::FIX_DIV_LAST; // R2
		tick = pre_pulse && s_r.div_cnt == 20'h0_0000;
		if (base_en) begin
			s_nxt.fix_cnt = s_r.fix_cnt + 6'h01; // R2
		end
		if (tick) begin
			s_nxt.div_cnt = s_r.prescale; // R3
		end else if (pre_pulse) begin
			s_nxt.div_cnt = s_r.div_cnt - 20'h0_0001;
		end

		// Bus write, performed once address and data are both held
		wr_do = s_r.aw_got && s_r.w_got; // R18
		time_wr = wr_do && s_r.aw_addr == rtc_pkg::ADDR_TIME;
		wv = 32'h0000_0000;
		time_inc = s_r.time_cnt + 32'h0000_0001;
		alarm_hit = tick && !time_wr && time_inc == s_r.alarm; // R6 R19
		if (time_wr) begin
			s_nxt.time_cnt = merge(s_r.time_cnt, s_r.wdata, s_r.wstrb);
		end else if (tick) begin
			s_nxt.time_cnt = time_inc; // R5 R8
		end

		cyc_hit = 1'b0;
		if (tick && s_r.cyc_en && s_r.cyc_n != 32'h0000_0000) begin // R7
			if (s_r.cyc_cnt + 32'h0000_0001 >= s_r.cyc_n) begin
				cyc_hit = 1'b1;
				s_nxt.cyc_cnt = 32'h0000_0000;
			end else begin
				s_nxt.cyc_cnt = s_r.cyc_cnt + 32'h0000_0001;
			end
		end

		// Timed exit from power down, armed on entry
		s_nxt.pd_d = powerdown_mode;
		wake_hit = 1'b0;
		if (powerdown_mode && !s_r.pd_d && s_r.pwd_wake) begin // R10
			s_nxt.wake_arm = 1'b1;
			s_nxt.wake_cnt = s_r.wake_dly;
		end else if (!powerdown_mode) begin
			s_nxt.wake_arm = 1'b0;
		end else if (s_r.wake_arm && tick) begin
			if (s_r.wake_cnt == 32'h0000_0000) begin
				wake_hit = 1'b1; // R10
				s_nxt.wake_arm = 1'b0;
			end else begin
				s_nxt.wake_cnt = s_r.wake_cnt - 32'h0000_0001;
			end
		end

		s_nxt.tick_req  = tick; // R4
		s_nxt.alarm_req = alarm_hit; // R6
		s_nxt.ext_irq = (tick && s_r.sel_tick) || // R9
			(alarm_hit && s_r.sel_alarm);
		s_nxt.wake = wake_hit || (powerdown_mode && s_nxt.ext_irq); // R9

		// Bus channels, either order for address and data
		if (s_axi_awvalid && s_axi_awready) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = s_axi_wdata;
			s_nxt.wstrb = s_axi_wstrb;
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (wr_do) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = mapped(s_r.aw_addr) ? rtc_pkg::RESP_OKAY
				: rtc_pkg::RESP_SLVERR;
			unique case (s_r.aw_addr)
				rtc_pkg::ADDR_CLK_CTRL: begin
					wv = merge({29'h0000_0000, s_r.cyc_en, s_r.osc_off,
						s_r.run}, s_r.wdata, s_r.wstrb);
					s_nxt.run     = wv[rtc_pkg::CTRL_RUN];
					s_nxt.osc_off = wv[rtc_pkg::CTRL_OSC_OFF];
					s_nxt.cyc_en  = wv[rtc_pkg::CTRL_CYC_EN];
				end
				rtc_pkg::ADDR_PRESCALE: begin
					wv = merge({12'h000, s_r.prescale}, s_r.wdata,
						s_r.wstrb);
					s_nxt.prescale = wv[19:0];
				end
				rtc_pkg::ADDR_ALARM:
					s_nxt.alarm = merge(s_r.alarm, s_r.wdata, s_r.wstrb);
				rtc_pkg::ADDR_CYCLE_N:
					s_nxt.cyc_n = merge(s_r.cyc_n, s_r.wdata, s_r.wstrb);
				rtc_pkg::ADDR_MASK: begin
					wv = merge({28'h000_0000, s_r.mask}, s_r.wdata,
						s_r.wstrb);
					s_nxt.mask = wv[3:0];
				end
				rtc_pkg::ADDR_WAKE_DLY: s_nxt.wake_dly =
					merge(s_r.wake_dly, s_r.wdata, s_r.wstrb);
				rtc_pkg::ADDR_SRC_SEL: begin
					wv = merge({30'h0000_0000, s_r.sel_alarm,
						s_r.sel_tick}, s_r.wdata, s_r.wstrb);
					s_nxt.sel_tick  = wv[rtc_pkg::SEL_TICK];
					s_nxt.sel_alarm = wv[rtc_pkg::SEL_ALARM];
				end
				rtc_pkg::ADDR_SYS_CFG: begin
					wv = merge({31'h0000_0000, s_r.pwd_wake}, s_r.wdata,
						s_r.wstrb);
					s_nxt.pwd_wake = wv[rtc_pkg::CFG_PWD_WAKE];
				end
				default: wv = 32'h0000_0000;
			endcase
		end

		// Read; a status read clears it but new events still win
		rd_do = s_axi_arvalid && s_axi_arready;
		st_clr = 4'h0;
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (rd_do) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = mapped(s_axi_araddr) ? rtc_pkg::RESP_OKAY
				: rtc_pkg::RESP_SLVERR;
			s_nxt.rdata = rd_mux(s_r, s_axi_araddr, main_osc_enable,
				lp_osc_enable);
			if (s_axi_araddr == rtc_pkg::ADDR_STATUS) begin
				st_clr = 4'hF;
			end
		end
		events = 4'h0;
		events[rtc_pkg::ST_TICK]  = tick;
		events[rtc_pkg::ST_ALARM] = alarm_hit;
		events[rtc_pkg::ST_CYCLE] = cyc_hit;
		events[rtc_pkg::ST_WAKE]  = wake_hit;
		s_nxt.status = (s_r.status & ~st_clr) | events;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_r <= '0;
			s_r.prescale <= rtc_pkg::PRESCALE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	chk_osc_off_pd: assert property ( // R11
		powerdown_mode && s_r.osc_off |-> !main_osc_enable && !lp_osc_enable)
		else $error("oscillator left on with osc-off in power down");
	chk_disabled_pd: assert property ( // R12
		powerdown_mode && !s_r.run |-> !main_osc_enable && !lp_osc_enable)
		else $error("oscillator on while disabled in power down");
	chk_lp_pd_main: assert property ( // R14
		powerdown_mode && s_r.lp_sel |-> !main_osc_enable)
		else $error("main oscillator on with 32 kHz source");
	chk_lp_standby: assert property ( // R15
		standby_mode && s_r.lp_sel && s_r.run && !s_r.osc_off
		|-> lp_osc_enable && !main_osc_enable)
		else $error("stand-by gating wrong with 32 kHz source");
	chk_main_standby: assert property ( // R16
		standby_mode && !s_r.lp_sel |=> $stable(s_r.fix_cnt))
		else $error("counter moved in stand-by on main source");
	chk_main_pd_on: assert property ( // R17
		powerdown_mode && !standby_mode && !s_r.lp_sel && s_r.run &&
		!s_r.osc_off |-> main_osc_enable)
		else $error("main oscillator stopped in power down");
	chk_div_reload: assert property ( // R3
		tick |=> s_r.div_cnt == $past(s_r.prescale) && s_r.fix_cnt == 6'h00)
		else $error("divider not reloaded at tick");
	chk_time_adv: assert property ( // R5
		tick && !time_wr |=> s_r.time_cnt == $past(s_r.time_cnt) + 1 &&
		tick_interrupt_request)
		else $error("time counter or tick request wrong");
	chk_alarm_pulse: assert property ( // R19
		alarm_hit |=> alarm_interrupt_request ##1 !alarm_interrupt_request)
		else $error("alarm request not a single pulse");
	chk_alarm_match: assert property ( // R6
		tick && !time_wr && s_r.time_cnt + 1 == s_r.alarm
		|=> s_r.status[rtc_pkg::ST_ALARM])
		else $error("alarm equality not flagged");
	chk_ext_route: assert property ( // R9
		tick && s_r.sel_tick |=> fast_ext_irq)
		else $error("tick not routed to fast interrupt");
	chk_det_window: assert property ( // R13
		!s_r.det_done && s_r.det_cnt != DET_LAST |=> !s_r.det_done && !s_r.lp_sel)
		else $error("source chosen before detection ended");

endmodule : rtc_prescaler_alarm_counter

//--- bench/rtc_prescaler_alarm_counter_tb.sv
`timescale 1ns/1ps
module rtc_prescaler_alarm_counter_tb;
	typedef struct packed {
		logic [31:0] d;
		logic [31:0] m;
		logic [1:0]  r;
	} exp_t;

	logic        clk, nrst, low_power_oscillator_input, powerdown_mode;
	logic        standby_mode, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic        tick_interrupt_request, alarm_interrupt_request;
	logic        fast_ext_irq, wake_request, main_osc_enable, lp_osc_enable;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rng;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, pin_cnt;
	logic        pin_run;
	exp_t        exp_q[$];
	exp_t        mon_e;
	int          fails, n_checks, n, nt, nf, na;

	rtc_prescaler_alarm_counter #(
		.DETECT_CYCLES(64)
	) u_rtc_prescaler_alarm_counter (
		.clk, .nrst, .low_power_oscillator_input, .powerdown_mode,
		.standby_mode, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .irq, .tick_interrupt_request,
		.alarm_interrupt_request, .fast_ext_irq, .wake_request,
		.main_osc_enable, .lp_osc_enable
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Pin toggles every 4 clocks while running: well above the detect count
	always @(posedge clk) begin
		pin_cnt <= pin_cnt + 2'h1;
		if (pin_run && pin_cnt == 2'h3)
			low_power_oscillator_input <= ~low_power_oscillator_input;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Ready is sampled mid-cycle, so the release lands on the taking edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] r = rtc_pkg::RESP_OKAY);
		logic ad, wd, ta, tw;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		while (!(ad && wd)) begin
			@(negedge clk);
			ta = !ad && s_axi_awready === 1'b1;
			tw = !wd && s_axi_wready === 1'b1;
			@(posedge clk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			ad = ad | ta;
			wd = wd | tw;
		end
		do @(negedge clk); while (s_axi_bvalid !== 1'b1);
		chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
		@(posedge clk);
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d,
			input logic [31:0] m = 32'hFFFF_FFFF,
			input logic [1:0] r = rtc_pkg::RESP_OKAY);
		@(posedge clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		exp_q.push_back(exp_t'{d, m, r});
		do @(negedge clk); while (s_axi_arready !== 1'b1);
		@(posedge clk);
		s_axi_arvalid <= 1'b0;
		do @(negedge clk); while (s_axi_rvalid !== 1'b1);
		@(posedge clk);
		s_axi_rready <= 1'b0;
	endtask : rd

	// Read data is judged against the oldest note when the handshake shows
	always @(negedge clk) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk("note", 32'h1, 32'h0);
			end else begin
				mon_e = exp_q.pop_front();
				chk("rdata", mon_e.d & mon_e.m, s_axi_rdata & mon_e.m);
				chk("rresp", {30'h0, mon_e.r}, {30'h0, s_axi_rresp});
			end
		end
	end

	function automatic logic sig(input int i);
		case (i)
			0: return tick_interrupt_request;
			1: return alarm_interrupt_request;
			2: return fast_ext_irq;
			default: return wake_request;
		endcase
	endfunction : sig

	task automatic waitev(input int i, input int lim);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (sig(i) !== 1'b1 && n < lim);
		chk("wait_event", 32'h1, {31'h0, sig(i) === 1'b1});
	endtask : waitev

	task automatic cnt(input int cyc);
		nt = 0;
		nf = 0;
		na = 0;
		repeat (cyc) begin
			@(negedge clk);
			nt += int'(sig(0) === 1'b1);
			na += int'(sig(1) === 1'b1);
			nf += int'(sig(2) === 1'b1);
		end
	endtask : cnt

	initial begin
		#800_000;
		fails++;
		wrap_up();
	end

	initial begin
		rng = 32'h1;
		{fails, n_checks, pin_run, pin_cnt} = '0;
		{nrst, low_power_oscillator_input, powerdown_mode} = '0;
		{standby_mode, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		repeat (80) @(posedge clk);
		rd(rtc_pkg::ADDR_CLK_CTRL, 32'h0);
		rd(rtc_pkg::ADDR_PRESCALE, {12'h0, rtc_pkg::PRESCALE_RST});
		rd(rtc_pkg::ADDR_CLK_INFO, 32'h2, 32'h3);
		rd(8'h30, 32'h0, 32'hFFFF_FFFF, rtc_pkg::RESP_SLVERR);
		wr(8'h30, 32'h1, rtc_pkg::RESP_SLVERR);
		wr(rtc_pkg::ADDR_DIVIDER, 32'hFFFF_FFFF);
		rd(rtc_pkg::ADDR_DIVIDER, 32'h0);
		for (int i = 0; i < 4; i++) begin
			rng = xs(rng);
			wr(rtc_pkg::ADDR_ALARM, rng);
			rd(rtc_pkg::ADDR_ALARM, rng);
		end
		// Prescale 1 gives a tick every 64 * 2 clocks on the main source
		wr(rtc_pkg::ADDR_PRESCALE, 32'h1);
		wr(rtc_pkg::ADDR_TIME, 32'h0);
		wr(rtc_pkg::ADDR_ALARM, 32'h3);
		wr(rtc_pkg::ADDR_MASK, 32'hF);
		wr(rtc_pkg::ADDR_CLK_CTRL, 32'h1);
		waitev(0, 400);
		waitev(0, 400);
		chk("tick_period", 32'd128, n);
		waitev(1, 400);
		chk("alarm_delay", 32'd128, n);
		chk("alarm_on_tick", 32'h1, {31'h0, tick_interrupt_request});
		chk("irq", 32'h1, {31'h0, irq});
		rd(rtc_pkg::ADDR_TIME, 32'h3);
		rd(rtc_pkg::ADDR_STATUS, 32'h3, 32'h7);
		cnt(400);
		chk("alarm_repeat", 32'h0, na);
		rd(rtc_pkg::ADDR_STATUS, 32'h0, 32'h2);
		wr(rtc_pkg::ADDR_MASK, 32'h0);
		chk("irq_masked", 32'h0, {31'h0, irq});
		wr(rtc_pkg::ADDR_CYCLE_N, 32'h2);
		wr(rtc_pkg::ADDR_CLK_CTRL, 32'h5);
		rd(rtc_pkg::ADDR_STATUS, 32'h0, 32'h0);
		repeat (3) waitev(0, 400);
		rd(rtc_pkg::ADDR_STATUS, 32'h4, 32'h4);
		wr(rtc_pkg::ADDR_SRC_SEL, 32'h1);
		cnt(400);
		chk("fast_tick", nt, nf);
		chk("ticks_seen", 32'h1, {31'h0, nt > 1});
		wr(rtc_pkg::ADDR_SRC_SEL, 32'h2);
		wr(rtc_pkg::ADDR_ALARM, 32'h1);
		wr(rtc_pkg::ADDR_TIME, 32'h0);
		cnt(300);
		chk("fast_alarm", 32'h1, nf);
		chk("alarm_once", 32'h1, na);
		wr(rtc_pkg::ADDR_SRC_SEL, 32'h0);
		wr(rtc_pkg::ADDR_SYS_CFG, 32'h1);
		wr(rtc_pkg::ADDR_WAKE_DLY, 32'h1);
		wr(rtc_pkg::ADDR_CLK_CTRL, 32'h1);
		@(posedge clk);
		powerdown_mode <= 1'b1;
		@(negedge clk);
		chk("main_pd_run", 32'h1, {31'h0, main_osc_enable});
		waitev(3, 600);
		chk("wake", 32'h1, {31'h0, wake_request});
		wr(rtc_pkg::ADDR_CLK_CTRL, 32'h3);
		chk("main_osc_off", 32'h0, {31'h0, main_osc_enable});
		wr(rtc_pkg::ADDR_CLK_CTRL, 32'h0);
		chk("both_off", 32'h0, {31'h0, main_osc_enable | lp_osc_enable});
		@(posedge clk);
		powerdown_mode <= 1'b0;
		wr(rtc_pkg::ADDR_CLK_CTRL, 32'h1);
		@(posedge clk);
		standby_mode <= 1'b1;
		@(negedge clk);
		chk("main_standby", 32'h0, {31'h0, main_osc_enable});
		@(posedge clk);
		standby_mode <= 1'b0;
		nrst <= 1'b0;
		pin_run <= 1'b1;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		repeat (80) @(posedge clk);
		rd(rtc_pkg::ADDR_CLK_INFO, 32'h3, 32'h3);
		wr(rtc_pkg::ADDR_CLK_CTRL, 32'h1);
		@(posedge clk);
		powerdown_mode <= 1'b1;
		@(negedge clk);
		chk("lp_pd_main", 32'h0, {31'h0, main_osc_enable});
		chk("lp_pd_lp", 32'h1, {31'h0, lp_osc_enable});
		@(posedge clk);
		standby_mode <= 1'b1;
		@(negedge clk);
		chk("lp_standby", 32'h1, {31'h0, lp_osc_enable});
		chk("pending", 32'h0, exp_q.size());
		wrap_up();
	end
endmodule : rtc_prescaler_alarm_counter_tb
